// ==== design/ihs_pkg.sv ====
package ihs_pkg;
   // command bit positions within the five low command bits
   localparam int CMD_W      = 5;
   localparam int CMD_START  = 0;
   localparam int CMD_RSTART = 1;
   localparam int CMD_STOP   = 2;
   localparam int CMD_RECV   = 3;
   localparam int CMD_ACK    = 4;
   localparam int BYTE_W     = 8;
   localparam int RELOAD_W   = 8;
   localparam int BITCNT_W   = 4;
   // last data bit index and acknowledge bit index
   localparam logic [3:0] LAST_DATA_BIT = 4'h7;
   localparam logic [3:0] ACK_BIT       = 4'h8;
   localparam logic [7:0] RELOAD_RST    = 8'h00;
   // host sequencer states
   typedef enum logic [3:0] {
      IHS_IDLE     = 4'b0000,
      IHS_ST_WAIT  = 4'b0001,
      IHS_ST_HOLD  = 4'b0010,
      IHS_RS_LOW   = 4'b0011,
      IHS_RS_SDAHI = 4'b0100,
      IHS_RS_SCLHI = 4'b0101,
      IHS_RS_SDALO = 4'b0110,
      IHS_TX_LOW   = 4'b0111,
      IHS_TX_HIGH  = 4'b1000,
      IHS_SP_SDALO = 4'b1001,
      IHS_SP_SCLHI = 4'b1010,
      IHS_SP_SDAHI = 4'b1011,
      IHS_SP_DONE  = 4'b1100
   } ihs_state_t;
endpackage

// ==== design/ihs_line_sync.sv ====
`timescale 1ns/10ps
`default_nettype none
// three-stage sampler for the two bus lines; a change is accepted once
// the second and third stages agree, which also filters single glitches
module ihs_line_sync (
   input  wire logic i_clk,
   input  wire logic i_arst_n,
   input  wire logic i_scl,
   input  wire logic i_sda,
   output logic      o_scl,
   output logic      o_sda
);
   typedef struct packed {
      logic [2:0] scl_sh;
      logic [2:0] sda_sh;
      logic       scl;
      logic       sda;
   } ihs_sync_t;
   ihs_sync_t r;
   ihs_sync_t next_r;

   ////////////////////////////////////////////////////////////////////////
   // shift and agree; idle bus reads high
   always_comb begin
      next_r        = r;
      next_r.scl_sh = {r.scl_sh[1:0], i_scl};
      next_r.sda_sh = {r.sda_sh[1:0], i_sda};
      if (r.scl_sh[1] == r.scl_sh[2]) begin
         next_r.scl = r.scl_sh[2];
      end
      if (r.sda_sh[1] == r.sda_sh[2]) begin
         next_r.sda = r.sda_sh[2];
      end
   end

   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         r <= '1;
      end else begin
         r <= next_r;
      end
   end

   assign o_scl = r.scl;
   assign o_sda = r.sda;
endmodule // ihs_line_sync
`default_nettype wire

// ==== design/ihs_host.sv ====
// Operation
// - host makes all clocks, start, stop
// - write: address byte with direction zero
// - read: address byte with direction one
// - released clock pauses counter until seen high
// - busy buffer write dropped, sets collision
// - command writes ignored during start
// - start: both high one period, SDA low
// - one more period, clear request, hold
// - start collision flags and goes idle
// - repeated start taken only when idle
// - repeated start stepped one period each
// - start seen early, event after timeout
// - repeated start collision checks
// - idle buffer write sets full, transmits
// - bit: low one period, high one period
// - after eighth bit, clear full, release
// - ninth clock captures acknowledge level
// - after ninth clock, event, suspend, hold low
// - no detection while generating; event at end
// - stop sequence with stop-seen flag
`timescale 1ns/10ps
`default_nettype none
module ihs_host (
   input  wire logic       i_clk,
   input  wire logic       i_arst_n,
   input  wire logic       i_link_clk,
   input  wire logic       i_enable,
   input  wire logic [7:0] i_baud_reload_value,
   input  wire logic [4:0] i_cmd_wdata,
   input  wire logic       i_cmd_we,
   input  wire logic [7:0] i_buf_wdata,
   input  wire logic       i_buf_we,
   input  wire logic       i_write_collision_flag_clr,
   input  wire logic       i_event_clr,
   input  wire logic       i_bcol_clr,
   input  wire logic       i_scl,
   input  wire logic       i_sda,
   output logic            o_scl_oe,
   output logic            o_scl_o,
   output logic            o_sda_oe,
   output logic            o_sda_o,
   output logic [4:0]      o_command_control_register,
   output logic            o_buffer_full_flag,
   output logic            o_ack_status_bit,
   output logic            o_write_collision_flag,
   output logic            o_serial_event_flag,
   output logic            o_bus_collision_flag,
   output logic            o_start_seen,
   output logic            o_stop_seen,
   output logic [7:0]      o_transfer_buffer
);
   ////////////////////////////////////////////////////////////////////////
   // link-clock domain: line watcher; start/stop detection on the lines
   typedef struct packed {
      logic [2:0] scl_sh;
      logic [2:0] sda_sh;
      logic       scl;
      logic       sda;
      logic       st_tgl;
      logic       sp_tgl;
   } ihs_link_t;
   ihs_link_t l;
   ihs_link_t next_l;

   always_comb begin
      next_l        = l;
      next_l.scl_sh = {l.scl_sh[1:0], i_scl};
      next_l.sda_sh = {l.sda_sh[1:0], i_sda};
      if (l.scl_sh[1] == l.scl_sh[2]) begin
         next_l.scl = l.scl_sh[2];
      end
      if (l.sda_sh[1] == l.sda_sh[2]) begin
         next_l.sda = l.sda_sh[2];
      end
      // sda falls with scl high: start; sda rises: stop
      if (l.scl && next_l.scl && l.sda && !next_l.sda) begin
         next_l.st_tgl = ~l.st_tgl;
      end
      if (l.scl && next_l.scl && !l.sda && next_l.sda) begin
         next_l.sp_tgl = ~l.sp_tgl;
      end
   end

   always_ff @(posedge i_link_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         l <= '1;
      end else begin
         l <= next_l;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // system-clock line sampler used by the sequencer
   logic scl_s;
   logic sda_s;

   ihs_line_sync u_sync (
      .i_clk    (i_clk),
      .i_arst_n (i_arst_n),
      .i_scl    (i_scl),
      .i_sda    (i_sda),
      .o_scl    (scl_s),
      .o_sda    (sda_s)
   );

   ////////////////////////////////////////////////////////////////////////
   // main state
   typedef struct packed {
      ihs_pkg::ihs_state_t        st;
      logic [7:0]                 cnt;
      logic                       run;
      logic [3:0]                 bitn;
      logic [7:0]                 shreg;
      logic [7:0]                 tbuf;
      logic [4:0]                 cmd;
      logic                       scl_oe;
      logic                       sda_oe;
      logic                       bf;
      logic                       ack;
      logic                       write_collision_flag;
      logic                       evt;
      logic                       bcol;
      logic                       s_seen;
      logic                       p_seen;
      logic                       gen;
      logic [2:0]                 st_sy;
      logic [2:0]                 sp_sy;
   } ihs_main_t;
   ihs_main_t r;
   ihs_main_t next_r;

   // counter expiry at zero while running
   logic tick;
   assign tick = r.run && (r.cnt == ihs_pkg::RELOAD_RST);

   always_comb begin
      logic st_ev;
      logic sp_ev;
      next_r = r;
      st_ev  = 1'b0;
      sp_ev  = 1'b0;
      // toggle crossing from link domain; stage 0 read only by stage 1
      next_r.st_sy = {r.st_sy[1:0], l.st_tgl};
      next_r.sp_sy = {r.sp_sy[1:0], l.sp_tgl};
      st_ev = r.st_sy[2] ^ r.st_sy[1];
      sp_ev = r.sp_sy[2] ^ r.sp_sy[1];
      // counter runs down, holding at zero until reloaded
      if (r.run && r.cnt != ihs_pkg::RELOAD_RST) begin
         next_r.cnt = r.cnt - 8'h01;
      end
      // detection masked while own start/stop generation runs
      if (!r.gen && st_ev) begin
         next_r.s_seen = 1'b1;
         next_r.p_seen = 1'b0;
      end
      if (!r.gen && sp_ev) begin
         next_r.p_seen = 1'b1;
         next_r.s_seen = 1'b0;
      end
      // software clears; a set in the same cycle wins below
      if (i_write_collision_flag_clr) begin
         next_r.write_collision_flag = 1'b0;
      end
      if (i_event_clr) begin
         next_r.evt = 1'b0;
      end
      if (i_bcol_clr) begin
         next_r.bcol = 1'b0;
      end
      // buffer write: taken when idle, else dropped
      if (i_buf_we) begin
         if (r.st == ihs_pkg::IHS_IDLE && r.cmd == '0) begin
            next_r.tbuf   = i_buf_wdata;
            next_r.shreg  = i_buf_wdata;
            next_r.bf     = 1'b1;
            next_r.bitn   = '0;
            next_r.sda_oe = ~i_buf_wdata[7];
            next_r.scl_oe = 1'b1;
            next_r.cnt    = i_baud_reload_value;
            next_r.run    = 1'b1;
            next_r.st     = ihs_pkg::IHS_TX_LOW;
         end else begin
            next_r.write_collision_flag = 1'b1;
         end
      end
      // command writes; ignored during a start, only acted on when idle
      if (i_cmd_we && r.cmd == '0 && r.st == ihs_pkg::IHS_IDLE
          && !i_buf_we) begin
         next_r.cmd = i_cmd_wdata & (~i_cmd_wdata + 5'h01); // lowest bit
         if (i_cmd_wdata[ihs_pkg::CMD_START]) begin
            // both low at the start: collision
            if (!scl_s && !sda_s) begin
               next_r.bcol = 1'b1;
               next_r.cmd  = '0;
            end else begin
               next_r.st  = ihs_pkg::IHS_ST_WAIT;
               next_r.gen = 1'b1;
               next_r.run = 1'b0;
            end
         end else if (i_cmd_wdata[ihs_pkg::CMD_RSTART]) begin
            next_r.st     = ihs_pkg::IHS_RS_LOW;
            next_r.scl_oe = 1'b1;
            next_r.cnt    = i_baud_reload_value;
            next_r.run    = 1'b1;
         end else if (i_cmd_wdata[ihs_pkg::CMD_STOP]) begin
            next_r.st     = ihs_pkg::IHS_SP_SDALO;
            next_r.sda_oe = 1'b1;
            next_r.gen    = 1'b1;
            next_r.run    = 1'b0;
         end else begin
            // receive and acknowledge are not carried by this block
            next_r.cmd = '0;
         end
      end

      unique case (r.st)
         ihs_pkg::IHS_IDLE: begin
         end
         // wait both high, count one period, then pull sda low
         ihs_pkg::IHS_ST_WAIT: begin
            if (!r.run && scl_s && sda_s) begin
               next_r.cnt = i_baud_reload_value;
               next_r.run = 1'b1;
            end else if (r.run && !scl_s) begin
               next_r.bcol = 1'b1;
               next_r.cmd  = '0;
               next_r.run  = 1'b0;
               next_r.gen  = 1'b0;
               next_r.st   = ihs_pkg::IHS_IDLE;
            end else if (tick && sda_s) begin
               next_r.sda_oe = 1'b1;
               next_r.s_seen = 1'b1;
               next_r.p_seen = 1'b0;
               next_r.cnt    = i_baud_reload_value;
               next_r.st     = ihs_pkg::IHS_ST_HOLD;
            end
         end
         ihs_pkg::IHS_ST_HOLD: begin
            if (tick) begin
               next_r.cmd[ihs_pkg::CMD_START] = 1'b0;
               next_r.run    = 1'b0;
               next_r.scl_oe = 1'b1; // clock low, ready for first bit
               next_r.evt    = 1'b1;
               next_r.gen    = 1'b0;
               next_r.st     = ihs_pkg::IHS_IDLE;
            end
         end
         // scl low one period, then sda released
         ihs_pkg::IHS_RS_LOW: begin
            if (tick) begin
               next_r.sda_oe = 1'b0;
               next_r.cnt    = i_baud_reload_value;
               next_r.st     = ihs_pkg::IHS_RS_SDAHI;
            end
         end
         ihs_pkg::IHS_RS_SDAHI: begin
            if (tick && sda_s) begin
               next_r.scl_oe = 1'b0;
               next_r.run    = 1'b0;
               next_r.gen    = 1'b1;
               next_r.st     = ihs_pkg::IHS_RS_SCLHI;
            end
         end
         // counter paused until scl really high
         ihs_pkg::IHS_RS_SCLHI: begin
            if (!r.run) begin
               if (scl_s) begin
                  if (!sda_s) begin
                     next_r.bcol = 1'b1;
                     next_r.cmd  = '0;
                     next_r.gen  = 1'b0;
                     next_r.st   = ihs_pkg::IHS_IDLE;
                  end else begin
                     next_r.cnt = i_baud_reload_value;
                     next_r.run = 1'b1;
                  end
               end
            end else if (!scl_s) begin
               next_r.bcol = 1'b1;
               next_r.cmd  = '0;
               next_r.run  = 1'b0;
               next_r.gen  = 1'b0;
               next_r.st   = ihs_pkg::IHS_IDLE;
            end else if (tick) begin
               next_r.sda_oe = 1'b1;
               next_r.s_seen = 1'b1;
               next_r.cnt    = i_baud_reload_value;
               next_r.st     = ihs_pkg::IHS_RS_SDALO;
            end
         end
         ihs_pkg::IHS_RS_SDALO: begin
            if (tick) begin
               next_r.scl_oe = 1'b1; // no reload, counter stops
               next_r.run    = 1'b0;
               next_r.cmd[ihs_pkg::CMD_RSTART] = 1'b0;
               next_r.evt    = 1'b1;
               next_r.gen    = 1'b0;
               next_r.st     = ihs_pkg::IHS_IDLE;
            end
         end
         // bit low phase: data moves one clock after scl fell, for hold
         ihs_pkg::IHS_TX_LOW: begin
            if (r.bitn == ihs_pkg::ACK_BIT) begin
               next_r.bf     = 1'b0;
               next_r.sda_oe = 1'b0;
            end else begin
               next_r.sda_oe = ~r.shreg[7];
            end
            if (tick) begin
               next_r.scl_oe = 1'b0;
               next_r.run    = 1'b0;
               next_r.st     = ihs_pkg::IHS_TX_HIGH;
            end
         end
         ihs_pkg::IHS_TX_HIGH: begin
            if (!r.run) begin
               if (scl_s) begin
                  next_r.cnt = i_baud_reload_value;
                  next_r.run = 1'b1;
                  if (r.bitn == ihs_pkg::ACK_BIT) begin
                     next_r.ack = sda_s;
                  end
               end
            end else if (tick) begin
               next_r.scl_oe = 1'b1;
               next_r.cnt    = i_baud_reload_value;
               if (r.bitn == ihs_pkg::ACK_BIT) begin
                  next_r.evt    = 1'b1;
                  next_r.run    = 1'b0;
                  next_r.sda_oe = 1'b0;
                  next_r.st     = ihs_pkg::IHS_IDLE;
               end else if (r.bitn == ihs_pkg::LAST_DATA_BIT) begin
                  next_r.bitn   = ihs_pkg::ACK_BIT;
                  next_r.st     = ihs_pkg::IHS_TX_LOW;
               end else begin
                  next_r.shreg  = {r.shreg[6:0], 1'b0}; // msb first
                  next_r.bitn   = r.bitn + 4'h1;
                  next_r.st     = ihs_pkg::IHS_TX_LOW;
               end
            end
         end
         // stop: sda low, wait seen low, one period, release scl
         ihs_pkg::IHS_SP_SDALO: begin
            if (!r.run && !sda_s) begin
               next_r.cnt = i_baud_reload_value;
               next_r.run = 1'b1;
            end else if (tick) begin
               next_r.scl_oe = 1'b0;
               next_r.run    = 1'b0;
               next_r.st     = ihs_pkg::IHS_SP_SCLHI;
            end
         end
         ihs_pkg::IHS_SP_SCLHI: begin
            if (!r.run && scl_s) begin
               next_r.cnt = i_baud_reload_value;
               next_r.run = 1'b1;
            end else if (tick) begin
               next_r.sda_oe = 1'b0;
               next_r.run    = 1'b0;
               next_r.st     = ihs_pkg::IHS_SP_SDAHI;
            end
         end
         ihs_pkg::IHS_SP_SDAHI: begin
            if (scl_s && sda_s) begin
               next_r.p_seen = 1'b1;
               next_r.s_seen = 1'b0;
               next_r.cnt    = i_baud_reload_value;
               next_r.run    = 1'b1;
               next_r.st     = ihs_pkg::IHS_SP_DONE;
            end
         end
         ihs_pkg::IHS_SP_DONE: begin
            if (tick) begin
               next_r.cmd[ihs_pkg::CMD_STOP] = 1'b0;
               next_r.evt = 1'b1;
               next_r.run = 1'b0;
               next_r.gen = 1'b0;
               next_r.st  = ihs_pkg::IHS_IDLE;
            end
         end
         default: begin
            next_r.st = ihs_pkg::IHS_IDLE;
         end
      endcase

      // disable: idle, lines released, requests dropped
      if (!i_enable) begin
         next_r.st     = ihs_pkg::IHS_IDLE;
         next_r.cmd    = '0;
         next_r.scl_oe = 1'b0;
         next_r.sda_oe = 1'b0;
         next_r.run    = 1'b0;
         next_r.gen    = 1'b0;
         next_r.bf     = 1'b0;
         next_r.s_seen = 1'b0;
         next_r.p_seen = 1'b0;
      end
   end

   // reset releases both lines and clears all requests
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         r       <= '0;
         r.st    <= ihs_pkg::IHS_IDLE;
         r.st_sy <= '1;
         r.sp_sy <= '1;
      end else begin
         r <= next_r;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // outputs: enables and flags straight from flip-flops; open drain drives low only
   assign o_scl_oe                   = r.scl_oe;
   assign o_scl_o                    = 1'b0;
   assign o_sda_oe                   = r.sda_oe;
   assign o_sda_o                    = 1'b0;
   assign o_command_control_register = r.cmd;
   assign o_buffer_full_flag         = r.bf;
   assign o_ack_status_bit           = r.ack;
   assign o_write_collision_flag     = r.write_collision_flag;
   assign o_serial_event_flag        = r.evt;
   assign o_bus_collision_flag       = r.bcol;
   assign o_start_seen               = r.s_seen;
   assign o_stop_seen                = r.p_seen;
   assign o_transfer_buffer          = r.tbuf;
endmodule // ihs_host
`default_nettype wire

// ==== dv/ihs_host_props.sv ====
`timescale 1ns/10ps
`default_nettype none
module ihs_host_props (
   input wire logic       i_clk,
   input wire logic       i_arst_n,
   input wire logic       i_enable,
   input wire logic [7:0] i_baud_reload_value,
   input wire logic       i_buf_we,
   input wire logic       i_scl,
   input wire logic       o_scl_oe,
   input wire logic       o_sda_oe,
   input wire logic [4:0] o_command_control_register,
   input wire logic       o_buffer_full_flag,
   input wire logic       o_write_collision_flag,
   input wire logic       o_serial_event_flag,
   input wire logic       o_bus_collision_flag,
   input wire logic [7:0] o_transfer_buffer
);
   logic [9:0] hi_cnt;
   logic [9:0] lo_cnt;
   logic [9:0] per;
   default clocking @(posedge i_clk);
   endclocking
   default disable iff (!i_arst_n);
   assign per = {2'h0, i_baud_reload_value} + 10'h001;
   // saturating run lengths of released-high and driven-low clock
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         hi_cnt <= 10'h000;
         lo_cnt <= 10'h000;
      end else begin
         hi_cnt <= (!o_scl_oe && i_scl) ? hi_cnt + {9'h000, ~&hi_cnt} : 10'h000;
         lo_cnt <= o_scl_oe ? lo_cnt + {9'h000, ~&lo_cnt} : 10'h000;
      end
   end
   ////////////////////////////////////////////////////////////////////////
   a_busy_write_collision_flag: assert property (
      i_buf_we && o_buffer_full_flag && i_enable |=> o_write_collision_flag)
      else $error("busy buffer write left collision flag clear");
   a_busy_keep: assert property (
      i_buf_we && o_buffer_full_flag && i_enable |=> $stable(o_transfer_buffer))
      else $error("busy buffer write changed the buffer");
   a_cmd_locked: assert property (
      o_command_control_register[0] |=> o_command_control_register[4:1] == 4'h0)
      else $error("command taken while start in progress");
   a_start_done: assert property (
      i_enable && $past(i_enable) && !o_bus_collision_flag
      && $fell(o_command_control_register[0])
      |-> o_sda_oe && o_scl_oe ##[0:1] o_serial_event_flag)
      else $error("start ended without lines held or event");
   a_disable_idle: assert property (
      !i_enable |=> !o_scl_oe && !o_sda_oe
      && o_command_control_register == 5'h00)
      else $error("disable did not idle the host");
   a_scl_high_min: assert property (
      $rose(o_scl_oe) |-> hi_cnt >= per)
      else $error("clock high phase shorter than one period");
   a_scl_low_min: assert property (
      i_enable && !o_bus_collision_flag && $fell(o_scl_oe) |-> lo_cnt >= per)
      else $error("clock low phase shorter than one period");
   a_ack_release: assert property (
      i_enable && $fell(o_buffer_full_flag) |-> !o_sda_oe)
      else $error("data line held after eighth bit");
endmodule // ihs_host_props
bind ihs_host ihs_host_props u_props (.i_clk, .i_arst_n, .i_enable,
   .i_baud_reload_value, .i_buf_we, .i_scl, .o_scl_oe, .o_sda_oe,
   .o_command_control_register, .o_buffer_full_flag,
   .o_write_collision_flag, .o_serial_event_flag, .o_bus_collision_flag,
   .o_transfer_buffer);
`default_nettype wire

// ==== dv/ihs_client_model.sv ====
`timescale 1ns/10ps
`default_nettype none
// behavioural client; stretch applies at every clock fall, zero for none
module ihs_client_model (
   input  wire logic        i_scl,
   input  wire logic        i_sda,
   input  wire logic        i_ack_en,
   input  wire logic [15:0] i_stretch_ns,
   output logic             o_sda_oe,
   output logic             o_scl_oe,
   output logic [7:0]       o_rx_byte
);
   int cnt = 0;
   initial o_sda_oe = 1'b0;
   initial o_scl_oe = 1'b0;
   initial o_rx_byte = 8'h00;
   // data edge with clock high is start or stop: new byte
   always @(i_sda) if (i_scl) cnt = 0;
   // shift on rising clock, msb first
   always @(posedge i_scl) begin
      if (cnt < 8) o_rx_byte = {o_rx_byte[6:0], i_sda};
      cnt = cnt + 1;
   end
   // ack over ninth bit, then let go
   always @(negedge i_scl) begin
      if (cnt == 8) o_sda_oe = i_ack_en;
      if (cnt == 9) begin
         o_sda_oe = 1'b0;
         cnt = 0;
      end
      if (i_stretch_ns != 16'h0000) begin
         o_scl_oe = 1'b1;
         #(i_stretch_ns);
         o_scl_oe = 1'b0;
      end
   end
endmodule // ihs_client_model
`default_nettype wire

// ==== dv/tb_ihs_host.sv ====
`timescale 1ns/10ps
`default_nettype none
module tb_ihs_host;
   localparam logic [7:0] RELOAD = 8'h04;
   logic i_clk = 1'b0, i_link_clk = 1'b0, i_arst_n = 1'b0, i_enable = 1'b0;
   logic i_cmd_we = 1'b0, i_buf_we = 1'b0, pull = 1'b0, ack_en = 1'b0;
   logic i_write_collision_flag_clr = 1'b0, i_event_clr = 1'b0, i_bcol_clr = 1'b0;
   logic [4:0] i_cmd_wdata = 5'h00;
   logic [7:0] i_buf_wdata = 8'h00;
   logic [15:0] stretch = 16'h0000;
   logic o_scl_oe, o_sda_oe, o_buffer_full_flag, o_ack_status_bit, o_start_seen;
   logic o_write_collision_flag, o_serial_event_flag, o_bus_collision_flag;
   logic o_stop_seen, cl_scl_oe, cl_sda_oe, scl_w, sda_w;
   logic [4:0] cmd_q;
   logic [1:0] drv;
   logic [7:0] o_transfer_buffer, rx;
   int miscompares = 0;
   int n_tests = 0;
   always #10 i_clk = ~i_clk;
   always #24 i_link_clk = ~i_link_clk;
   // pulled-up wires: any party driving wins
   assign scl_w = ~(o_scl_oe | cl_scl_oe | pull);
   assign sda_w = ~(o_sda_oe | cl_sda_oe | pull);
   ihs_host u_dut (.i_clk, .i_arst_n, .i_link_clk, .i_enable,
      .i_baud_reload_value(RELOAD), .i_cmd_wdata, .i_cmd_we, .i_buf_wdata,
      .i_buf_we, .i_write_collision_flag_clr, .i_event_clr, .i_bcol_clr, .i_scl(scl_w),
      .i_sda(sda_w), .o_scl_oe, .o_scl_o(drv[1]), .o_sda_oe, .o_sda_o(drv[0]),
      .o_command_control_register(cmd_q), .o_buffer_full_flag,
      .o_ack_status_bit, .o_write_collision_flag, .o_serial_event_flag,
      .o_bus_collision_flag, .o_start_seen, .o_stop_seen, .o_transfer_buffer);
   ihs_client_model u_client (.i_scl(scl_w), .i_sda(sda_w), .i_ack_en(ack_en),
      .i_stretch_ns(stretch), .o_sda_oe(cl_sda_oe), .o_scl_oe(cl_scl_oe),
      .o_rx_byte(rx));
   ////////////////////////////////////////////////////////////////////////
   task wrap_up;
      $display("comparisons %0d mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task chk(input logic ok, input string msg);
      n_tests++;
      if (ok !== 1'b1) begin
         miscompares++;
         $display("[FAIL] %0t %s", $time, msg);
      end
   endtask
   task cmd(input logic [4:0] v);
      @(posedge i_clk) i_cmd_wdata <= v;
      i_cmd_we <= 1'b1;
      @(posedge i_clk) i_cmd_we <= 1'b0;
   endtask
   task bufw(input logic [7:0] v);
      @(posedge i_clk) i_buf_wdata <= v;
      i_buf_we <= 1'b1;
      @(posedge i_clk) i_buf_we <= 1'b0;
   endtask
   // bounded wait for the event flag, then clear it
   task wait_evt;
      int n;
      for (n = 0; n < 3000 && o_serial_event_flag !== 1'b1; n++) @(posedge i_clk);
      if (n == 3000) begin
         chk(1'b0, "event timeout");
         wrap_up;
      end
      @(posedge i_clk) i_event_clr <= 1'b1;
      @(posedge i_clk) i_event_clr <= 1'b0;
   endtask
   task lim(input int n);
      if (n >= 300) begin
         chk(1'b0, "wait timeout");
         wrap_up;
      end
   endtask
   ////////////////////////////////////////////////////////////////////////
   task t_start;
      int n;
      logic [7:0] keep;
      keep = o_transfer_buffer;
      cmd(5'h01);
      cmd(5'h02);
      bufw(8'h5A);
      @(posedge i_clk);
      chk(cmd_q === 5'h01, "second command taken");
      chk(o_write_collision_flag === 1'b1 && o_transfer_buffer === keep,
          "write during start");
      for (n = 0; n < 300 && o_sda_oe !== 1'b1; n++) @(posedge i_clk);
      lim(n);
      for (n = 0; n < 300 && cmd_q[0] === 1'b1; n++) @(posedge i_clk);
      lim(n);
      chk(n == RELOAD + 1, "start hold period");
      @(posedge i_clk) i_write_collision_flag_clr <= 1'b1;
      @(posedge i_clk) i_write_collision_flag_clr <= 1'b0;
      @(posedge i_clk);
      chk(o_write_collision_flag === 1'b0, "collision flag kept");
      wait_evt;
      chk(o_sda_oe === 1'b1 && o_scl_oe === 1'b1 && o_start_seen === 1'b1
          && cmd_q === 5'h00, "start end state");
      $display("test start done");
   endtask
   task t_byte(input logic [7:0] b, input logic ack, input logic [15:0] st);
      ack_en = ack;
      stretch = st;
      bufw(b);
      @(posedge i_clk);
      chk(o_buffer_full_flag === 1'b1 && o_transfer_buffer === b, "load");
      if (st != 16'h0000) begin
         bufw(~b);
         @(posedge i_clk);
         chk(o_write_collision_flag === 1'b1 && o_transfer_buffer === b,
             "write during byte");
         @(posedge i_clk) i_write_collision_flag_clr <= 1'b1;
         @(posedge i_clk) i_write_collision_flag_clr <= 1'b0;
      end
      wait_evt;
      chk(rx === b, "byte on wire");
      chk(o_ack_status_bit === ~ack, "ack status");
      chk(o_buffer_full_flag === 1'b0 && o_scl_oe === 1'b1 && o_sda_oe === 1'b0,
          "after ninth clock");
      stretch = 16'h0000;
      $display("test byte done");
   endtask
   task t_rstart;
      cmd(5'h02);
      wait_evt;
      chk(cmd_q === 5'h00 && o_sda_oe === 1'b1 && o_scl_oe === 1'b1,
          "repeated start end");
      $display("test repeated start done");
   endtask
   task t_stop;
      cmd(5'h04);
      wait_evt;
      chk(o_stop_seen === 1'b1 && o_scl_oe === 1'b0 && o_sda_oe === 1'b0
          && cmd_q === 5'h00, "stop end");
      chk(drv === 2'b00, "line drive level");
      $display("test stop done");
   endtask
   task t_bcol;
      int n;
      @(posedge i_clk) pull <= 1'b1;
      repeat (5) @(posedge i_clk);
      cmd(5'h01);
      for (n = 0; n < 300 && o_bus_collision_flag !== 1'b1; n++) @(posedge i_clk);
      lim(n);
      chk(o_bus_collision_flag === 1'b1 && cmd_q === 5'h00 && o_sda_oe === 1'b0
          && o_scl_oe === 1'b0, "start on low bus");
      @(posedge i_clk) pull <= 1'b0;
      i_bcol_clr <= 1'b1;
      @(posedge i_clk) i_bcol_clr <= 1'b0;
      repeat (5) @(posedge i_clk);
      chk(o_bus_collision_flag === 1'b0, "collision clear");
      $display("test bus collision done");
   endtask
   task t_disable;
      t_start;
      bufw(8'hC3);
      repeat (30) @(posedge i_clk);
      i_enable <= 1'b0;
      repeat (2) @(posedge i_clk);
      chk(o_scl_oe === 1'b0 && o_sda_oe === 1'b0 && cmd_q === 5'h00,
          "disable mid byte");
      i_enable <= 1'b1;
      repeat (3) @(posedge i_clk);
      $display("test disable done");
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (5) @(posedge i_clk);
      i_arst_n <= 1'b1;
      i_enable <= 1'b1;
      repeat (5) @(posedge i_clk);
      t_start;
      t_byte(8'hA4, 1'b1, 16'h0000);
      t_byte(8'h3C, 1'b0, 16'h00C8);
      t_rstart;
      t_byte(8'hA5, 1'b1, 16'h0000);
      t_stop;
      t_bcol;
      t_disable;
      wrap_up;
   end
endmodule // tb_ihs_host
`default_nettype wire
